// *** hdl/eivl_pkg.sv ***
`default_nettype none
package eivl_pkg;

  // register indices; the bus byte address is four times the index
  localparam logic [7:0] REG_B_IDX       = 8'h0a;
  localparam logic [7:0] REG_C_IDX       = 8'h0b;
  localparam logic [7:0] REG_OPTION_IDX  = 8'h1d;
  localparam logic [7:0] REG_CTRL_IDX    = 8'h20;
  localparam logic [7:0] REG_STATUS_IDX  = 8'h21;
  localparam logic [7:0] REG_VECTOR_IDX  = 8'h22;

  // pin control register fields, plus the option register edge-only bit
  localparam int FLAG_BIT    = 5;
  localparam int ENABLE_BIT  = 4;
  localparam int LEVEL_BIT   = 3;
  localparam int EDGE_BIT    = 2;
  localparam int CLEAR_BIT   = 1;
  localparam int VALUE_BIT   = 0;
  localparam int EDGE_ONLY_BIT = 1;
  localparam logic [3:0] PIN_CTRL_RESET = 4'h0;

  // own control register fields
  localparam int MASK_BIT       = 0;
  localparam int INSTR_DONE_BIT = 1;
  localparam int STOP_BIT       = 2;
  localparam int WAIT_BIT       = 3;
  localparam int SWI_BIT        = 4;
  localparam int RESET_REQ_BIT  = 5;

  // vector addresses, high byte at the even location
  localparam logic [15:0] VEC_RESET = 16'h3ffe;
  localparam logic [15:0] VEC_SWI   = 16'h3ffc;
  localparam logic [15:0] VEC_EXT   = 16'h3ffa;
  localparam logic [15:0] VEC_CTIM  = 16'h3ff8;
  localparam logic [15:0] VEC_I2C   = 16'h3ff6;
  localparam logic [15:0] VEC_T16   = 16'h3ff4;

  localparam logic [7:0] CORE_COUNT_MAX = 8'hff;
  localparam logic [7:0] RTI_COUNT_DEF  = 8'h40;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    EIVL_RUN  = 2'b00,
    EIVL_WAIT = 2'b01,
    EIVL_STOP = 2'b10
  } eivl_power_e;

  typedef struct packed {
    logic       intReq;
    logic [2:0] source;
    logic [15:0] vector;
  } eivl_request_s;

  typedef struct packed {
    logic       realtimeFlag;
    logic       realtimeEnable;
    logic       coreCounterOverflowFlag;
    logic       coreCounterOverflowEnable;
  } eivl_core_timer_s;

endpackage
`default_nettype wire

// *** hdl/eivl_top.sv ***
// Functional notes
// (RULE1) all three external pins share vector pair 3FFA high, 3FFB low
// (RULE2) interrupt mask set blocks every maskable request; clear allows service
// (RULE3) pin a falling edge is latched, then synchronised before reaching core; here the pin is synchronised first, then the edge is latched
// (RULE4) option bit 1 zero gives edge and low level on pin a, one edge only
// (RULE5) pin a edge-only bit resets to zero and accepts one write per reset
// (RULE6) pin b register: flag 5, enable 4, level 3, edge 2, clear 1, pin 0
// (RULE7) pin b enable bit lets pin b raise an interrupt
// (RULE8) level and edge selects pick falling, rising, falling+low, rising+high trigger
// (RULE9) valid pin b trigger sets pin b flag
// (RULE10) writing one to pin b clear strobe clears flag; strobe reads zero
// (RULE11) pin b value bit reads present pin b level
// (RULE12) pin c register has same layout, reset and enable as pin b
// (RULE13) writing one to pin c clear strobe clears flag; strobe reads zero
// (RULE14) pin c value bit reads present pin c level
// (RULE15) core timer request from realtime or overflow flag, vector 3FF8/3FF9
// (RULE16) realtime flag set after configured core timer counts once enabled
// (RULE17) overflow flag set when 8-bit core counter wraps ff to 00
// (RULE18) any of five 16-bit timer flags with enable requests vector 3FF4/3FF5
// (RULE19) i2c flag or three status flags with enable request vector 3FF6/3FF7
// (RULE20) reset sets the mask and selects reset vector 3FFE/3FFF
// (RULE21) stop turns oscillator off until external pin interrupt or reset
// (RULE22) wait halts cpu clocks, timers run; resume on reset, external, timer
// (RULE23) fixed priority: reset, swi, external, core timer, i2c, 16-bit timer
// (RULE24) pending requests are checked only when the current instruction ends
// (RULE25) each pin passes two flip-flops before edge and level qualification
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module eivl_top #(
  parameter int COUNT_WIDTH = 8
) (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      extIntPinA,
  input  wire logic                      extIntPinB,
  input  wire logic                      extIntPinC,
  input  wire logic [4:0]                timer16Flags,
  input  wire logic [4:0]                timer16Enables,
  input  wire logic [3:0]                i2cFlags,
  input  wire logic [3:0]                i2cEnables,
  input  wire logic                      coreCountTick,
  input  wire logic                      swiExec,
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic                           cpuIntTake,
  output eivl_pkg::eivl_request_s        cpuRequest,
  output logic                           oscEnable,
  output logic                           cpuClockEnable,
  output eivl_pkg::eivl_core_timer_s     coreTimerState
);
  import eivl_pkg::*;

  // pin synchronisers, first stage read only by the second
  logic [2:0] pinMeta_q;
  logic [2:0] pinSync_q;
  logic [2:0] pinPrev_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinMeta_q <= 3'h7;
      pinSync_q <= 3'h7;
      pinPrev_q <= 3'h7;
    end else begin
      pinMeta_q <= {extIntPinC, extIntPinB, extIntPinA}; // RULE25
      pinSync_q <= pinMeta_q; // RULE25
      pinPrev_q <= pinSync_q;
    end
  end

  wire [2:0] pinRise = pinSync_q & ~pinPrev_q;
  wire [2:0] pinFall = ~pinSync_q & pinPrev_q;

  // bus handshake
  logic awHeld_q, wHeld_q, bValid_q, rValid_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic [31:0] rData_q;
  logic [1:0] bResp_q, rResp_q;

  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready  = !wHeld_q && !bValid_q;
  assign s_axi_arready = !rValid_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;

  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake  = s_axi_wvalid && s_axi_wready;
  wire wrGo   = awHeld_q && wHeld_q;
  wire wrLane = wStrb_q[0];
  wire [5:0] wrIdx = awAddr_q[7:2];
  wire [5:0] rdIdx = s_axi_araddr[7:2];
  wire rdGo = s_axi_arvalid && s_axi_arready;

  function automatic logic hitReg(input logic [5:0] idx, input logic [7:0] reg_idx);
    hitReg = ({2'b00, idx} == reg_idx);
  endfunction

  wire wrB   = wrGo && wrLane && hitReg(wrIdx, REG_B_IDX);
  wire wrC   = wrGo && wrLane && hitReg(wrIdx, REG_C_IDX);
  wire wrOpt = wrGo && wrLane && hitReg(wrIdx, REG_OPTION_IDX);
  wire wrCtl = wrGo && wrLane && hitReg(wrIdx, REG_CTRL_IDX);
  wire wrVec = wrGo && wrLane && hitReg(wrIdx, REG_VECTOR_IDX);
  wire wrMapped = hitReg(wrIdx, REG_B_IDX) || hitReg(wrIdx, REG_C_IDX)
               || hitReg(wrIdx, REG_OPTION_IDX) || hitReg(wrIdx, REG_CTRL_IDX)
               || hitReg(wrIdx, REG_STATUS_IDX) || hitReg(wrIdx, REG_VECTOR_IDX);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      bValid_q <= 1'b0;
      bResp_q  <= RESP_OKAY;
      awAddr_q <= 8'h00;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
    end else begin
      if (awTake) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (wTake) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (wrGo) begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bValid_q && s_axi_bready) begin
        bValid_q <= 1'b0;
      end
    end
  end

  // pin a mode, write-once after reset
  logic edgeOnlyA_q, optWritten_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      edgeOnlyA_q  <= 1'b0; // RULE5
      optWritten_q <= 1'b0;
    end else if (wrOpt && !optWritten_q) begin
      edgeOnlyA_q  <= wData_q[EDGE_ONLY_BIT]; // RULE4
      optWritten_q <= 1'b1; // RULE5
    end
  end

  // pin a latch; level mode re-arms while the pin stays low
  logic pendA_q;
  wire trigA = pinFall[0] || (!edgeOnlyA_q && !pinSync_q[0]); // RULE3 RULE4

  // pins b and c
  logic [1:0] enable_q, level_q, edgeSel_q, flag_q;
  wire [1:0] wrBC = {wrC, wrB};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gPin
      wire pinNow = pinSync_q[g+1];
      wire trig = edgeSel_q[g]
                ? (pinRise[g+1] || (level_q[g] && pinNow))
                : (pinFall[g+1] || (level_q[g] && !pinNow)); // RULE8
      wire clr = wrBC[g] && wData_q[CLEAR_BIT]; // RULE10 RULE13
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          enable_q[g]  <= PIN_CTRL_RESET[0]; // RULE6 RULE12
          level_q[g]   <= PIN_CTRL_RESET[1];
          edgeSel_q[g] <= PIN_CTRL_RESET[2];
          flag_q[g]    <= PIN_CTRL_RESET[3];
        end else begin
          if (wrBC[g]) begin
            enable_q[g]  <= wData_q[ENABLE_BIT]; // RULE7 RULE12
            level_q[g]   <= wData_q[LEVEL_BIT];
            edgeSel_q[g] <= wData_q[EDGE_BIT];
          end
          // set wins over the clear strobe
          if (trig && enable_q[g]) begin
            flag_q[g] <= 1'b1; // RULE9
          end else if (clr) begin
            flag_q[g] <= 1'b0; // RULE10 RULE13
          end
        end
      end
    end
  endgenerate

  // core timer: counter driven by a one-cycle tick
  logic [COUNT_WIDTH-1:0] coreCount_q;
  logic [7:0] rtiCount_q;
  logic [7:0] rtiPeriod_q;
  logic rtiFlag_q, rtiEn_q, ovfFlag_q, ovfEn_q;
  wire wrStat = wrGo && wrLane && hitReg(wrIdx, REG_STATUS_IDX);
  wire rtiHit = coreCountTick && rtiEn_q && (rtiCount_q == rtiPeriod_q); // RULE16
  wire ovfHit = coreCountTick && ovfEn_q
              && (coreCount_q == COUNT_WIDTH'(CORE_COUNT_MAX)); // RULE17

  // counters only move on the tick; status flags clear by writing one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      coreCount_q <= '0;
      rtiCount_q  <= 8'h00;
      rtiPeriod_q <= RTI_COUNT_DEF;
      rtiEn_q     <= 1'b0;
      ovfEn_q     <= 1'b0;
      rtiFlag_q   <= 1'b0;
      ovfFlag_q   <= 1'b0;
    end else begin
      if (coreCountTick) begin
        coreCount_q <= coreCount_q + COUNT_WIDTH'(1); // wraps all ones to zero
        rtiCount_q  <= rtiHit ? 8'h00 : rtiCount_q + 8'h01;
      end
      if (wrVec) begin
        rtiPeriod_q <= wData_q[15:8];
        rtiEn_q     <= wData_q[0];
        ovfEn_q     <= wData_q[1];
      end
      if (rtiHit) begin
        rtiFlag_q <= 1'b1; // RULE16
      end else if (wrStat && wData_q[2]) begin
        rtiFlag_q <= 1'b0;
      end
      if (ovfHit) begin
        ovfFlag_q <= 1'b1; // RULE17
      end else if (wrStat && wData_q[3]) begin
        ovfFlag_q <= 1'b0;
      end
    end
  end

  assign coreTimerState = '{rtiFlag_q, rtiEn_q, ovfFlag_q, ovfEn_q};

  // cpu side control
  logic mask_q;
  logic instrDone_q;
  eivl_power_e power_q;
  wire extReq  = pendA_q || |flag_q;
  wire ctimReq = (rtiFlag_q && rtiEn_q) || (ovfFlag_q && ovfEn_q); // RULE15
  wire t16Req  = |(timer16Flags & timer16Enables); // RULE18
  wire i2cReq  = |(i2cFlags & i2cEnables); // RULE19
  wire anyHw   = !mask_q && (extReq || ctimReq || t16Req || i2cReq); // RULE2
  wire takeNow = instrDone_q && (swiExec || anyHw); // RULE24

  // fixed priority
  wire [15:0] vecSel = swiExec ? VEC_SWI
                     : extReq  ? VEC_EXT // RULE1
                     : ctimReq ? VEC_CTIM
                     : i2cReq  ? VEC_I2C
                     : VEC_T16; // RULE23
  wire [2:0] srcSel = swiExec ? 3'd1 : extReq ? 3'd2 : ctimReq ? 3'd3
                    : i2cReq ? 3'd4 : 3'd5;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pendA_q <= 1'b0;
    end else if (trigA) begin
      pendA_q <= 1'b1; // RULE3
    end else if (cpuIntTake && srcSel == 3'd2) begin
      pendA_q <= 1'b0; // cleared on entry to service
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mask_q      <= 1'b1; // RULE20
      instrDone_q <= 1'b0;
      power_q     <= EIVL_RUN;
      cpuIntTake  <= 1'b0;
      cpuRequest  <= '{1'b1, 3'd0, VEC_RESET}; // RULE20
    end else begin
      cpuIntTake <= takeNow;
      if (takeNow) begin
        cpuRequest <= '{1'b1, srcSel, vecSel};
        mask_q     <= 1'b1;
      end else if (wrCtl) begin
        mask_q      <= wData_q[MASK_BIT]; // RULE2
        instrDone_q <= wData_q[INSTR_DONE_BIT];
        cpuRequest.intReq <= 1'b0;
      end
      case (power_q)
        EIVL_RUN: begin
          if (wrCtl && wData_q[STOP_BIT]) begin
            power_q <= EIVL_STOP;
          end else if (wrCtl && wData_q[WAIT_BIT]) begin
            power_q <= EIVL_WAIT;
          end
        end
        EIVL_WAIT: begin
          if (extReq || ctimReq || t16Req) begin
            power_q <= EIVL_RUN; // RULE22
          end
        end
        EIVL_STOP: begin
          if (extReq) begin
            power_q <= EIVL_RUN; // RULE21
          end
        end
        default: begin
          power_q <= EIVL_RUN;
        end
      endcase
    end
  end

  assign oscEnable      = (power_q != EIVL_STOP); // RULE21
  assign cpuClockEnable = (power_q == EIVL_RUN); // RULE22

  // read path
  wire [7:0] regB = {2'b00, flag_q[0], enable_q[0], level_q[0], edgeSel_q[0],
                     1'b0, pinSync_q[1]}; // RULE11
  wire [7:0] regC = {2'b00, flag_q[1], enable_q[1], level_q[1], edgeSel_q[1],
                     1'b0, pinSync_q[2]}; // RULE14
  wire rdB   = hitReg(rdIdx, REG_B_IDX);
  wire rdC   = hitReg(rdIdx, REG_C_IDX);
  wire rdOpt = hitReg(rdIdx, REG_OPTION_IDX);
  wire rdCtl = hitReg(rdIdx, REG_CTRL_IDX);
  wire rdSt  = hitReg(rdIdx, REG_STATUS_IDX);
  wire rdVec = hitReg(rdIdx, REG_VECTOR_IDX);
  wire [31:0] rdVal = rdB ? {24'h00_0000, regB}
                    : rdC ? {24'h00_0000, regC}
                    : rdOpt ? {30'h0000_0000, edgeOnlyA_q, 1'b0}
                    : rdCtl ? {28'h000_0000, power_q, instrDone_q, mask_q}
                    : rdSt ? {28'h000_0000, ovfFlag_q, rtiFlag_q, pendA_q, extReq}
                    : rdVec ? {16'h0000, rtiPeriod_q, 6'h00, ovfEn_q, rtiEn_q}
                    : 32'h0000_0000;
  wire rdMapped = rdB || rdC || rdOpt || rdCtl || rdSt || rdVec;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rValid_q <= 1'b0;
      rData_q  <= 32'h0000_0000;
      rResp_q  <= RESP_OKAY;
    end else if (rdGo) begin
      rValid_q <= 1'b1;
      rData_q  <= rdVal;
      rResp_q  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rValid_q && s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** dv/eivl_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module eivl_sva (
  input wire logic                       clk,
  input wire logic                       resetn,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic                       s_axi_bvalid,
  input wire logic [7:0]                 s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic [1:0]                 s_axi_rresp,
  input wire logic                       s_axi_rvalid,
  input wire logic                       cpuIntTake,
  input wire eivl_pkg::eivl_request_s    cpuRequest,
  input wire logic                       oscEnable,
  input wire logic                       cpuClockEnable,
  input wire eivl_pkg::eivl_core_timer_s coreTimerState
);
  import eivl_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire arTake = s_axi_arvalid && s_axi_arready;
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  a_read_resp: assert property (arTake |=> s_axi_rvalid) else $error("read data late");
  a_strobe_zero: assert property (arTake && (s_axi_araddr == 8'h28 || s_axi_araddr == 8'h2c)
    |=> s_axi_rdata[CLEAR_BIT] == 1'h0 && s_axi_rresp == RESP_OKAY) else $error("strobe reads one");
  a_unmapped_err: assert property (arTake && s_axi_araddr == 8'hf0
    |=> s_axi_rresp == RESP_SLVERR) else $error("unmapped read not refused");
  a_reset_vector: assert property ($rose(resetn) |-> cpuRequest.vector == VEC_RESET
    && cpuRequest.source == 3'h0) else $error("reset vector wrong");
  // vector pairs step down by two per priority level
  a_vector_table: assert property (cpuRequest.intReq
    |-> cpuRequest.vector == 16'h3ffe - {12'h000, cpuRequest.source, 1'h0})
    else $error("vector does not match source");
  a_take_once: assert property (cpuIntTake |=> !cpuIntTake) else $error("take repeated");
  a_stop_halts: assert property (!oscEnable |-> !cpuClockEnable) else $error("cpu runs in stop");
  a_ovf_needs_en: assert property ($rose(coreTimerState.coreCounterOverflowFlag)
    |-> $past(coreTimerState.coreCounterOverflowEnable)) else $error("overflow flag unenabled");
  a_rti_needs_en: assert property ($rose(coreTimerState.realtimeFlag)
    |-> $past(coreTimerState.realtimeEnable)) else $error("realtime flag unenabled");
  c_take: cover property (cpuIntTake);
  c_stop: cover property (!oscEnable);
  c_wait: cover property (oscEnable && !cpuClockEnable);
  c_ovf: cover property ($rose(coreTimerState.coreCounterOverflowFlag));
endmodule
bind eivl_top eivl_sva u_sva (.*);
`default_nettype wire

// *** dv/eivl_far_end.sv ***
`timescale 1ns/100ps
`default_nettype none
module eivl_far_end (
  input wire logic                    clk,
  input wire logic                    cpuIntTake,
  input wire eivl_pkg::eivl_request_s cpuRequest,
  output logic [2:0]                  pins
);
  import eivl_pkg::*;
  int            takes = 0;
  eivl_request_s lastReq;
  // pins idle high, as with external pull-ups
  initial pins = 3'h7;
  // core side: one vector fetch recorded per taken request
  always @(posedge clk) begin
    if (cpuIntTake) begin
      takes <= takes + 1;
      lastReq <= cpuRequest;
    end
  end
  task automatic setPin(input int i, input logic v);
    @(posedge clk);
    pins[i] <= v;
  endtask
endmodule
`default_nettype wire

// *** dv/tb_external_irq_and_vector_logic.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_external_irq_and_vector_logic;
  import eivl_pkg::*;
  logic             clk, resetn, coreCountTick, swiExec, cpuIntTake, oscEnable, cpuClockEnable;
  logic [7:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]      s_axi_wdata, s_axi_rdata;
  logic [3:0]       s_axi_wstrb, i2cFlags, i2cEnables;
  logic [4:0]       timer16Flags, timer16Enables;
  logic [1:0]       s_axi_bresp, s_axi_rresp;
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic             s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0]       pins;
  eivl_request_s    cpuRequest;
  eivl_core_timer_s coreTimerState;
  int               n_mismatch = 0;
  int               checks_done = 0;
  eivl_top u_dut (.*, .extIntPinA(pins[0]), .extIntPinB(pins[1]), .extIntPinC(pins[2]));
  eivl_far_end u_far (.clk, .cpuIntTake, .cpuRequest, .pins);
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic tmo();
    chk("timeout", 32'h0, 32'h1);
    final_report();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'h0;
    r = s_axi_bresp;
    if (n == 50) tmo();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n == 50) tmo();
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, e, d & m);
  endtask
  // four edges cover the two-flop synchroniser plus edge detection
  task automatic pin(input int p, input logic v);
    u_far.setPin(p, v);
    repeat (4) @(posedge clk);
  endtask
  task automatic s_reset();
    rchk("pin b reset", 8'h28, 32'h3f, 32'h01);
    rchk("pin c reset", 8'h2c, 32'h3f, 32'h01);
    rchk("option reset", 8'h74, 32'h02, 32'h00);
  endtask
  task automatic s_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    rd(8'hf0, d, r);
    chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(8'hf0, 32'h1, r);
    chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
  endtask
  task automatic s_pins(input int p);
    logic [7:0]  a;
    logic [31:0] m;
    logic        act;
    a = (p == 1) ? 8'h28 : 8'h2c;
    for (int i = 0; i < 4; i++) begin
      act = i[0];
      m = 32'h10 | (32'(i) << 2);
      // disable first: a held level of the old mode would win over the clear
      w(a, 32'h00);
      pin(p, !act);
      w(a, m | 32'h02);
      rchk("pin idle", a, 32'h3f, m | {31'h0, !act});
      pin(p, act);
      rchk("pin trigger", a, 32'h3f, m | 32'h20 | {31'h0, act});
      // a held level re-arms the flag straight after the clear, an edge does not
      w(a, m | 32'h02);
      rchk("clear while active", a, 32'h3f, m | {26'h0, i[1], 4'h0, act});
      pin(p, !act);
      w(a, m | 32'h02);
      rchk("pin clear", a, 32'h3f, m | {31'h0, !act});
    end
    w(a, 32'h00);
    pin(p, 1'h1);
    w(a, 32'h02);
    pin(p, 1'h0);
    rchk("pin disabled", a, 32'h3f, 32'h00);
    pin(p, 1'h1);
  endtask
  task automatic waitTake(input int k);
    for (int n = 0; n < 30 && u_far.takes != k; n++) @(posedge clk);
    chk("take count", 32'(k), 32'(u_far.takes));
    if (u_far.takes != k) tmo();
  endtask
  task automatic s_pin_a();
    w(8'h80, 32'h03);
    pin(0, 1'h0);
    repeat (20) @(posedge clk);
    chk("masked take", 32'h0, 32'(u_far.takes));
    w(8'h80, 32'h02);
    waitTake(1);
    chk("ext vector", {16'h0, VEC_EXT}, {16'h0, u_far.lastReq.vector});
    w(8'h80, 32'h02);
    waitTake(2);
    // pin high again: one more service drops the latch
    pin(0, 1'h1);
    w(8'h80, 32'h02);
    waitTake(3);
    w(8'h74, 32'h02);
    w(8'h74, 32'h00);
    rchk("option once", 8'h74, 32'h02, 32'h02);
    pin(0, 1'h0);
    w(8'h80, 32'h02);
    waitTake(4);
    w(8'h80, 32'h02);
    repeat (20) @(posedge clk);
    chk("edge only no rearm", 32'h4, 32'(u_far.takes));
    pin(0, 1'h1);
  endtask
  task automatic s_power();
    w(8'h80, 32'h09);
    repeat (3) @(posedge clk);
    chk("wait clocks", 32'h2, {30'h0, oscEnable, cpuClockEnable});
    timer16Flags <= 5'h10;
    timer16Enables <= 5'h10;
    for (int n = 0; n < 30 && !cpuClockEnable; n++) @(posedge clk);
    chk("wait wake", 32'h3, {30'h0, oscEnable, cpuClockEnable});
    timer16Flags <= 5'h00;
    w(8'h28, 32'h12);
    w(8'h80, 32'h05);
    repeat (3) @(posedge clk);
    chk("stop clocks", 32'h0, {30'h0, oscEnable, cpuClockEnable});
    u_far.setPin(1, 1'h0);
    for (int n = 0; n < 30 && !oscEnable; n++) @(posedge clk);
    chk("stop wake", 32'h1, {31'h0, oscEnable});
    pin(1, 1'h1);
    w(8'h28, 32'h02);
  endtask
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk);
      coreCountTick <= 1'h1;
      @(posedge clk);
      coreCountTick <= 1'h0;
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic s_timer();
    w(8'h88, 32'h0000_0402);
    tick(255);
    chk("no wrap yet", 32'h0, {31'h0, coreTimerState.coreCounterOverflowFlag});
    tick(1);
    chk("wrap", 32'h1, {31'h0, coreTimerState.coreCounterOverflowFlag});
    chk("rti off", 32'h0, {31'h0, coreTimerState.realtimeFlag});
    w(8'h88, 32'h0000_0403);
    tick(8);
    chk("rti set", 32'h1, {31'h0, coreTimerState.realtimeFlag});
    w(8'h84, 32'h0c);
    repeat (2) @(posedge clk);
    chk("flags cleared", 32'h0, {30'h0, coreTimerState.realtimeFlag,
      coreTimerState.coreCounterOverflowFlag});
  endtask
  initial begin
    {resetn, coreCountTick, swiExec, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {i2cFlags, i2cEnables, timer16Flags, timer16Enables} = '0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    s_reset();
    s_unmapped();
    s_pins(1);
    s_pins(2);
    s_pin_a();
    s_power();
    s_timer();
    final_report();
  end
endmodule
`default_nettype wire
